// ---- rtl/sfe_front_end.sv ----
// sfe_front_end: spi slave front end of a serial flash, plus a small byte fifo
// assumes pins arrive asynchronously; array back end sits on clk_sys_i
// Contract
// RL1 - capture input bits on serial clock rise
// RL2 - change output bit on serial clock fall
// RL3 - support modes 0 and 3 alike
// RL4 - select on chip select falling edge
// RL5 - drive busy on output during auto-increment
// RL6 - master holds select low while pausing
// RL7 - pause when pause falls with clock low
// RL8 - pause falling during high clock waits
// RL9 - resume on rise with clock low, keep progress
// RL10 - paused: output floats, input and clock ignored
// RL11 - deselect while paused resets interface logic
// RL12 - paused while pause low; resume needs both
// RL13 - pin low and lockdown set rejects status write
// RL14 - pin high always allows status write
// RL15 - erase addressing by 4k, 32k, 64k units
// RL16 - serial clock up to 50 MHz; the oversampling front end manages about an eighth of clk_sys_i
// RL17 - protect bits guard array and status; here only chip erase checks them, on prot_q[2:0]
// RL18 - master polls busy bit until clear
// RL19 - writes need write enable first
// RL20 - eight-bit cycles, most significant first
// RL21 - early deselect aborts instruction, back to standby
// RL22 - reset lockdown 0, low protect bits 1
// RL23 - output floats unless selected and not paused
`timescale 1ns/1ps

module sfe_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 4
) (
   input  wire logic             clk_sys_i,
   input  wire logic             rst_b_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   output logic      [WIDTH-1:0] out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;
   assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o  = mem_q[rd_q];

   function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
      nxt = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : nxt

   // storage and pointers
   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wr_q <= nxt(wr_q);
         if (pop)  rd_q <= nxt(rd_q);
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : sfe_fifo

module sfe_front_end
   import sfe_pkg::*;
#(
   parameter int unsigned FIFO_W = 16,
   parameter int unsigned FIFO_D = sfe_pkg::FIFO_DEPTH
) (
   input  wire logic                  clk_sys_i,
   input  wire logic                  rst_b_i,
   input  wire logic                  sck_i,
   input  wire logic                  sel_b_i,
   input  wire logic                  sdi_i,
   input  wire logic                  pause_b_i,
   input  wire logic                  wprot_b_i,
   output logic                       sdo_o,
   output logic                       sdo_oe_o,
   input  wire logic                  busy_i,
   input  wire logic                  auto_inc_end_i,
   output sfe_pkg::sfe_byte_t         byte_o,
   output logic                       byte_valid_o,
   input  wire logic                  byte_ready_i,
   output sfe_pkg::sfe_req_t          req_o,
   output logic                       req_valid_o,
   output logic [7:0]                 status_o,
   output logic                       overrun_o
);
   import sfe_pkg::*;

   logic [1:0] sck_s_q, sel_s_q, sdi_s_q, hold_s_q, wp_s_q;
   logic       sck_p_q;
   logic       sck_rise, sck_fall, sck_lo;
   logic       paused_q, hold_cmd;
   logic       active_q;
   logic [2:0] bit_q;
   logic [7:0] sh_q;
   logic [7:0] op_q;
   logic [2:0] idx_q;
   logic [ADDR_BITS-1:0] addr_q;
   logic [7:0] out_q;
   logic       so_busy_q;
   logic       wr_latch_q, auto_inc_q, lock_q;
   logic [3:0] prot_q;
   logic       byte_done;
   logic [7:0] rx_byte;
   logic       f_in_rdy;
   sfe_byte_t  f_in, f_out;
   logic       f_out_v;

   // two-flop synchronisers on every pin
   // oversampling limits the usable serial clock to about an eighth of clk_sys_i,
   // well below the 50 MHz pin ceiling; a faster link needs a pin-clocked shifter [RL16]
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sck_s_q  <= '0;
         sel_s_q  <= 2'b11;
         sdi_s_q  <= '0;
         hold_s_q <= 2'b11;
         wp_s_q   <= 2'b11;
         sck_p_q  <= 1'b0;
      end else begin
         sck_s_q  <= {sck_s_q[0], sck_i};
         sel_s_q  <= {sel_s_q[0], sel_b_i};
         sdi_s_q  <= {sdi_s_q[0], sdi_i};
         hold_s_q <= {hold_s_q[0], pause_b_i};
         wp_s_q   <= {wp_s_q[0], wprot_b_i};
         sck_p_q  <= sck_s_q[1];
      end
   end

   // edges seen only on the second stage; idle level is irrelevant [RL3]
   assign sck_rise = sck_s_q[1] && !sck_p_q && !sel_s_q[1] && !paused_q;   // [RL10]
   assign sck_fall = !sck_s_q[1] && sck_p_q && !sel_s_q[1] && !paused_q;   // [RL10]
   assign sck_lo   = !sck_s_q[1];
   assign hold_cmd = !hold_s_q[1];

   // pause enters and leaves only while the clock is low, or ends on deselect at any clock level [RL7] [RL8] [RL9]
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         paused_q <= 1'b0;
      end else if (sel_s_q[1]) begin
         paused_q <= 1'b0;                        // deselect clears the pause [RL11]
      end else if (sck_lo) begin
         paused_q <= hold_cmd;                    // stays while pause held low [RL12]
      end
   end

   // frame tracking; a fresh select starts at the opcode [RL4]
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         active_q <= 1'b0;
      end else begin
         active_q <= !sel_s_q[1];
      end
   end

   assign rx_byte   = {sh_q[6:0], sdi_s_q[1]};
   assign byte_done = sck_rise && (bit_q == 3'd7);

   // shift in msb first on the rising edge [RL1] [RL20]
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bit_q <= '0;
         sh_q  <= '0;
         idx_q <= '0;
         op_q  <= '0;
      end else if (sel_s_q[1] || !active_q) begin
         bit_q <= '0;                             // partial byte dropped [RL21] [RL11]
         idx_q <= '0;
      end else if (sck_rise) begin
         sh_q  <= rx_byte;
         bit_q <= bit_q + 3'd1;
         if (bit_q == 3'd7) begin
            if (idx_q == 3'd0) op_q <= rx_byte;
            if (idx_q != 3'd7) idx_q <= idx_q + 3'd1;
         end
      end
   end

   // address collected from bytes 1 to 3
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         addr_q <= '0;
      end else if (byte_done && idx_q >= 3'd1 && idx_q <= 3'd3) begin
         addr_q <= ADDR_BITS'({addr_q, rx_byte});
      end
   end

   // write-protect pin high makes the lockdown bit a don't care
   function automatic logic status_wr_ok(input logic wp_b, input logic lock);
      status_wr_ok = wp_b || !lock;               // [RL13] [RL14]
   endfunction : status_wr_ok

   function automatic logic needs_addr(input logic [7:0] op);
      needs_addr = (op == OP_PROG) || (op == OP_SECT) || (op == OP_BLK32) ||
                   (op == OP_BLK64) || (op == OP_AUTO_INC);
   endfunction : needs_addr

   // status bits; an instruction acts once its deciding byte is whole, without waiting for deselect [RL21]
   // the write enable latch is spent by every accepted write or erase except auto-increment, which keeps it until auto_inc_end_i
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_latch_q  <= 1'b0;
         auto_inc_q  <= 1'b0;
         lock_q      <= STATUS_RESET[LOCKDOWN_POS];            // [RL22]
         prot_q      <= STATUS_RESET[PROT_LSB +: 4];           // [RL22]
         req_valid_o <= 1'b0;
         req_o       <= '0;
         so_busy_q   <= 1'b0;
      end else begin
         req_valid_o <= 1'b0;
         if (auto_inc_end_i) begin
            auto_inc_q <= 1'b0;
            wr_latch_q <= 1'b0;
         end
         if (byte_done && idx_q == 3'd0) begin
            case (rx_byte)
               OP_WR_ENABLE: wr_latch_q <= 1'b1;
               OP_WRDI: wr_latch_q <= 1'b0;
               OP_EBSY: so_busy_q <= 1'b1;
               OP_DBSY: so_busy_q <= 1'b0;
               OP_CHIP: begin
                  if (wr_latch_q && prot_q[2:0] == 3'b000 && !busy_i) begin  // [RL19] [RL17]
                     req_o       <= '{erase: 1'b1, kind: SFE_ERASE_CHIP, addr: '0};
                     req_valid_o <= 1'b1;
                     wr_latch_q  <= 1'b0;
                  end
               end
               default: ;
            endcase
         end
         if (byte_done && idx_q == 3'd1 && op_q == OP_STATUS_WR) begin
            if (wr_latch_q && status_wr_ok(wp_s_q[1], lock_q)) begin  // [RL19] [RL13] [RL14]
               lock_q <= rx_byte[LOCKDOWN_POS];
               prot_q <= rx_byte[PROT_LSB +: 4];
            end
            wr_latch_q <= 1'b0;
         end
         if (byte_done && idx_q == 3'd3 && needs_addr(op_q) && wr_latch_q && !busy_i) begin
            // erase units are 4k, 32k and 64k by opcode [RL15]
            req_o.erase <= (op_q != OP_PROG) && (op_q != OP_AUTO_INC);
            req_o.kind  <= (op_q == OP_BLK32) ? SFE_ERASE_B32 :
                           (op_q == OP_BLK64) ? SFE_ERASE_B64 : SFE_ERASE_SECTOR;
            req_o.addr  <= ADDR_BITS'({addr_q, rx_byte});
            req_valid_o <= 1'b1;
            // auto-increment keeps the latch until the back end ends the run
            if (op_q == OP_AUTO_INC) auto_inc_q <= 1'b1;
            else wr_latch_q <= 1'b0;
         end
      end
   end

   // output shift on the falling edge; busy on the pin during auto-increment [RL2] [RL5]
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         out_q <= '0;
         sdo_o <= 1'b0;
      end else if (sel_s_q[1]) begin
         sdo_o <= 1'b0;
      end else if (auto_inc_q && so_busy_q && op_q != OP_RDSR) begin
         sdo_o <= !busy_i;                        // ready high, busy low
      end else if (sck_fall) begin
         if (bit_q == 3'd0) begin
            out_q <= {status_o[6:0], 1'b0};
            sdo_o <= status_o[7];                 // status read, msb first [RL20]
         end else begin
            out_q <= {out_q[6:0], 1'b0};
            sdo_o <= out_q[7];
         end
      end
   end

   // pin drive only while selected and not paused [RL23] [RL10]
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sdo_oe_o <= 1'b0;
      end else begin
         sdo_oe_o <= !sel_s_q[1] && !paused_q &&
                     ((op_q == OP_RDSR && idx_q != 3'd0) || (auto_inc_q && so_busy_q));
      end
   end

   // status image for the host poll of the busy bit [RL18]
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         status_o <= STATUS_RESET;
      end else begin
         status_o <= {lock_q, auto_inc_q, prot_q, wr_latch_q, busy_i};
      end
   end

   // received bytes flow through the fifo; a full fifo flags an overrun
   assign f_in = '{data: rx_byte, opcode: (idx_q == 3'd0) ? rx_byte : op_q, index: idx_q};

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         overrun_o <= 1'b0;
      end else if (sel_s_q[1]) begin
         overrun_o <= 1'b0;
      end else if (byte_done && !f_in_rdy) begin
         overrun_o <= 1'b1;                       // serial side cannot be stalled
      end
   end

   sfe_fifo #(.WIDTH($bits(sfe_byte_t)), .DEPTH(FIFO_D)) u_fifo (
      .clk_sys_i   (clk_sys_i),
      .rst_b_i     (rst_b_i),
      .in_data_i   (f_in),
      .in_valid_i  (byte_done),
      .in_ready_o  (f_in_rdy),
      .out_data_o  (f_out),
      .out_valid_o (f_out_v),
      .out_ready_i (byte_ready_i)
   );

   // fifo head is already a register; byte_o mirrors it to flops, byte_valid_o follows it only while byte_ready_i is low
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         byte_o       <= '0;
         byte_valid_o <= 1'b0;
      end else begin
         byte_o       <= f_out;
         byte_valid_o <= f_out_v && !byte_ready_i;
      end
   end
endmodule : sfe_front_end

// ---- rtl/sfe_pkg.sv ----
// sfe_pkg: shared constants and carrier types for the serial flash front end
// assumes a 100 MHz system clock that oversamples the serial clock pin
package sfe_pkg;
   localparam int unsigned CLK_SYS_MHZ    = 100;
   localparam int unsigned SCK_MAX_MHZ    = 50;   // serial clock ceiling
   localparam int unsigned BYTE_BITS      = 8;
   localparam int unsigned SECTOR_KBYTE   = 4;
   localparam int unsigned BLOCK32_KBYTE  = 32;
   localparam int unsigned BLOCK64_KBYTE  = 64;
   localparam int unsigned ADDR_BITS      = 19;   // 4 Mbit array
   localparam int unsigned FIFO_DEPTH     = 4;
   localparam int unsigned LOCKDOWN_POS   = 7;
   localparam int unsigned AUTO_INC_POS   = 6;
   localparam int unsigned WR_LATCH_POS   = 1;
   localparam int unsigned BUSY_POS       = 0;
   localparam int unsigned PROT_LSB       = 2;
   localparam logic [7:0]  STATUS_RESET   = 8'h1C;  // lockdown 0, levels 0..2 set
   // opcodes the front end itself must recognise
   localparam logic [7:0]  OP_WR_ENABLE   = 8'h06;
   localparam logic [7:0]  OP_WRDI        = 8'h04;
   localparam logic [7:0]  OP_RDSR        = 8'h05;
   localparam logic [7:0]  OP_STATUS_WR   = 8'h01;
   localparam logic [7:0]  OP_PROG        = 8'h02;
   localparam logic [7:0]  OP_AUTO_INC    = 8'hAD;
   localparam logic [7:0]  OP_SECT        = 8'h20;
   localparam logic [7:0]  OP_BLK32       = 8'h52;
   localparam logic [7:0]  OP_BLK64       = 8'hD8;
   localparam logic [7:0]  OP_CHIP        = 8'h60;
   localparam logic [7:0]  OP_EBSY        = 8'h70;
   localparam logic [7:0]  OP_DBSY        = 8'h80;

   typedef enum logic [1:0] {SFE_ERASE_SECTOR, SFE_ERASE_B32, SFE_ERASE_B64,
                             SFE_ERASE_CHIP} sfe_erase_t;

   // one received byte with its position inside the frame
   typedef struct packed {
      logic [7:0] data;
      logic [7:0] opcode;
      logic [2:0] index;   // 0 opcode, 1..3 address, 4+ data (saturating)
   } sfe_byte_t;

   // erase or program request to the array back end
   typedef struct packed {
      logic                 erase;
      sfe_erase_t           kind;
      logic [ADDR_BITS-1:0] addr;
   } sfe_req_t;
endpackage : sfe_pkg

// ---- testbench/sfe_front_end_properties.sv ----
// sfe_front_end_properties: port level checks on the serial flash front end
// assumes it is bound into sfe_front_end and sees only its ports
`timescale 1ns/1ps
module sfe_front_end_properties
   import sfe_pkg::*;
(
   input wire logic         clk_sys_i,
   input wire logic         rst_b_i,
   input wire logic         sck_i,
   input wire logic         sel_b_i,
   input wire logic         pause_b_i,
   input wire logic         wprot_b_i,
   input wire logic         sdo_o,
   input wire logic         sdo_oe_o,
   input sfe_pkg::sfe_byte_t byte_o,
   input wire logic         byte_valid_o,
   input wire logic         byte_ready_i,
   input sfe_pkg::sfe_req_t  req_o,
   input wire logic         req_valid_o,
   input wire logic   [7:0] status_o,
   input wire logic         overrun_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);

   // four cycles cover the pin synchroniser delay
   oe_idle_a: assert property (sel_b_i [*4] |-> !sdo_oe_o)
      else $error("output driven while deselected");
   stat_reset_a: assert property ($rose(rst_b_i) |-> status_o == STATUS_RESET)
      else $error("status wrong after reset");
   req_pulse_a: assert property (req_valid_o |=> !req_valid_o)
      else $error("request longer than one cycle");
   req_latch_a: assert property (req_valid_o |-> $past(status_o[WR_LATCH_POS]))
      else $error("request without write enable");
   chip_prot_a: assert property (req_valid_o && req_o.erase &&
      req_o.kind == SFE_ERASE_CHIP |-> $past(status_o[4:2]) == 3'h0)
      else $error("chip erase while protected");
   lock_hold_a: assert property ((!wprot_b_i && status_o[LOCKDOWN_POS]) [*4]
      |=> $stable(status_o[7]) && $stable(status_o[5:2]))
      else $error("locked status changed");
   pause_float_a: assert property ((!pause_b_i && !sck_i) [*6] |-> !sdo_oe_o)
      else $error("output driven while paused");
   // busy mode follows the back end, not the serial clock
   sdo_edge_a: assert property (sdo_oe_o && $past(sdo_oe_o) &&
      !status_o[AUTO_INC_POS] && $changed(sdo_o) |-> !$past(sck_i, 3))
      else $error("output changed away from a falling edge");
   byte_hold_a: assert property (byte_valid_o && !byte_ready_i // fifo output holds
      |=> byte_valid_o && $stable(byte_o))
      else $error("byte lost while stalled");
   cover property (req_valid_o);
   cover property (byte_valid_o && byte_ready_i);
   cover property (overrun_o);
   cover property (sdo_oe_o);
endmodule : sfe_front_end_properties

bind sfe_front_end sfe_front_end_properties u_props (.clk_sys_i, .rst_b_i,
   .sck_i, .sel_b_i, .pause_b_i, .wprot_b_i, .sdo_o, .sdo_oe_o, .byte_o,
   .byte_valid_o, .byte_ready_i, .req_o, .req_valid_o, .status_o, .overrun_o);

// ---- testbench/sfe_spi_master.sv ----
// sfe_spi_master: behavioural spi bus master for the front end pins
// assumes a 100 MHz clock; one serial clock half period is 8 clocks
`timescale 1ns/1ps
module sfe_spi_master (
   input  wire logic clk_sys_i,
   input  wire logic sdo_i,
   input  wire logic sdo_oe_i,
   output logic      sck_o,
   output logic      sel_b_o,
   output logic      sdi_o,
   output logic      pause_b_o
);
   logic mode_q = 1'b0;
   logic last_q = 1'b0;
   // a released output toggles, so a float never reads as data
   wire  so_w = sdo_oe_i ? sdo_i : ~last_q;
   always @(posedge clk_sys_i) last_q <= so_w;
   initial begin
      sck_o = 1'b0;
      sel_b_o = 1'b1;
      sdi_o = 1'b0;
      pause_b_o = 1'b1;
   end
   task automatic half();
      repeat (8) @(posedge clk_sys_i);
      #1;
   endtask : half
   // idle clock level picks mode 0 or 3
   task automatic start(input logic m3);
      mode_q = m3;
      sck_o = m3;
      half();
      sel_b_o = 1'b0;
      half();
   endtask : start
   task automatic stop();
      sck_o = mode_q;
      half();
      sel_b_o = 1'b1;
      half();
   endtask : stop
   // hold 1 pauses with clock low, 2 with clock high, 3 deselects in pause
   task automatic xb(input logic [7:0] tx, output logic [7:0] rx,
                     input int nb = 8, input int hold = 0);
      for (int i = 7; i >= 8 - nb; i--) begin
         sck_o = 1'b0;
         sdi_o = tx[i]; // msb first
         half();
         sck_o = 1'b1;
         rx[i] = so_w;
         half();
         if (hold != 0 && i == 4) begin
            if (hold == 1) sck_o = 1'b0;
            pause_b_o = 1'b0; // select stays low
            half();
            sck_o = 1'b0;
            half();
            // junk edges while paused must be ignored
            repeat (4) begin
               sck_o = ~sck_o;
               sdi_o = ~sdi_o;
               half();
            end
            if (hold == 3) begin
               sel_b_o = 1'b1;
               half();
               pause_b_o = 1'b1;
               return;
            end
            pause_b_o = 1'b1;
            half();
         end
      end
   endtask : xb
endmodule : sfe_spi_master

// ---- testbench/tb_serial_flash_spi_front_end.sv ----
// tb_serial_flash_spi_front_end: self-checking bench for sfe_front_end
// assumes the spi master model and the bound checker compile alongside
`timescale 1ns/1ps
module tb_serial_flash_spi_front_end;
   import sfe_pkg::*;
   logic clk_sys_i = 0, rst_b_i = 0, wprot_b_i = 1, busy_i = 0;
   logic auto_inc_end_i = 0, byte_ready_i = 1, ovr_q = 0;
   wire  sck_i, sel_b_i, sdi_i, pause_b_i, sdo_o, sdo_oe_o;
   wire  byte_valid_o, req_valid_o, overrun_o;
   wire  [7:0] status_o;
   sfe_byte_t  byte_o;
   sfe_req_t   req_o, req_q;
   int         err_count = 0, total_checks = 0, req_n = 0, n0;
   logic [31:0] seed = 32'hf6a25e13;
   logic [47:0] a;
   logic [7:0]  rx, d;
   logic [7:0]  ops [4] = '{OP_SECT, OP_BLK32, OP_BLK64, OP_CHIP};

   sfe_front_end u_dut (.clk_sys_i, .rst_b_i, .sck_i, .sel_b_i, .sdi_i,
      .pause_b_i, .wprot_b_i, .sdo_o, .sdo_oe_o, .busy_i, .auto_inc_end_i, .byte_o,
      .byte_valid_o, .byte_ready_i, .req_o, .req_valid_o, .status_o, .overrun_o);
   sfe_spi_master u_m (.clk_sys_i, .sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o),
      .sck_o(sck_i), .sel_b_o(sel_b_i), .sdi_o(sdi_i), .pause_b_o(pause_b_i));

   always #5 clk_sys_i = ~clk_sys_i;
   // request pulses last one cycle and overrun clears on deselect, so catch them here
   always @(posedge clk_sys_i) begin
      if (req_valid_o === 1'b1) begin
         req_q <= req_o;
         req_n <= req_n + 1;
      end
      if (overrun_o === 1'b1) ovr_q <= 1'b1;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // status after a write: lockdown and levels taken, write enable cleared
   function automatic logic [7:0] sx(input logic [7:0] v);
      return {v[7], 1'b0, v[5:2], 2'b00};
   endfunction : sx
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask : cyc
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // opcode then n bytes of v, msb first, random mode per frame
   task automatic cmd(input logic [7:0] op, input logic [47:0] v, input int n,
                      input int hold = 0);
      u_m.start(1'(rnd()));
      u_m.xb(op, rx);
      for (int k = n - 1; k >= 0; k--) u_m.xb(v[8*k+:8], rx, 8, k == 0 ? hold : 0);
      u_m.stop();
      cyc(4);
   endtask : cmd
   task automatic rdsr_chk(input logic [7:0] exp);
      u_m.start(1'(rnd()));
      u_m.xb(OP_RDSR, rx);
      u_m.xb(8'h00, rx);
      u_m.stop();
      chk(rx, exp);
   endtask : rdsr_chk
   task automatic report_and_stop();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : report_and_stop

   initial begin
      // nearly fifty frames of a few hundred cycles each, with ample margin
      #600_000;
      err_count++;
      report_and_stop();
   end

   initial begin
      cyc(16);
      rst_b_i = 1;
      cyc(4);
      chk(status_o, STATUS_RESET);
      cmd(OP_WR_ENABLE, 0, 0);
      cmd(OP_CHIP, 0, 0);
      chk(req_n, 0);
      // random status writes, paused in mid-byte with both clock phases
      for (int i = 0; i < 6; i++) begin
         d = (i == 5) ? 8'h00 : 8'(rnd()) & 8'h3C;
         cmd(OP_WR_ENABLE, 0, 0);
         cmd(OP_STATUS_WR, 48'(d), 1, i % 3);
         rdsr_chk(sx(d));
      end
      cmd(OP_WR_ENABLE, 0, 0);
      cmd(OP_STATUS_WR, 48'h1C, 1, 3);
      chk(status_o & 8'hFC, 0);
      cmd(OP_WRDI, 0, 0);
      u_m.start(1'b0);
      u_m.xb(OP_WR_ENABLE, rx, 5);
      u_m.stop();
      chk(status_o[WR_LATCH_POS], 0);
      // lockdown table: pin low obeys lockdown, pin high ignores it
      for (int i = 0; i < 3; i++) begin
         wprot_b_i = (i == 2);
         cmd(OP_WR_ENABLE, 0, 0);
         cmd(OP_STATUS_WR, 48'(i == 0 ? 8'h84 : i == 1 ? 8'h1C : 8'h00), 1);
         chk(status_o & 8'hFC, i == 2 ? 8'h00 : 8'h84);
      end
      a = 48'(rnd()) & 48'h7_FFFF;
      n0 = req_n;
      cmd(OP_SECT, a, 3);
      busy_i = 1;
      cmd(OP_WR_ENABLE, 0, 0);
      cmd(OP_SECT, a, 3);
      chk(status_o[BUSY_POS], 1);
      busy_i = 0;
      chk(req_n, n0);
      for (int i = 0; i < 4; i++) begin
         a = 48'(rnd()) & 48'h7_FFFF;
         n0 = req_n;
         cmd(OP_WR_ENABLE, 0, 0);
         cmd(ops[i], a, i == 3 ? 0 : 3);
         chk(req_n, n0 + 1);
         chk({req_q.erase, req_q.kind}, 4 + i);
         if (i < 3) chk(req_q.addr, a[18:0]);
      end
      // program while the consumer stalls: fifo fills, then drains in order
      a = {8'h00, 8'(rnd()) & 8'h07, rnd()};
      cmd(OP_WR_ENABLE, 0, 0);
      byte_ready_i = 0;
      cmd(OP_PROG, a, 6);
      chk({req_q.erase, req_q.addr}, {1'b0, a[42:24]});
      chk(ovr_q, 1);
      for (int k = 0; k < 4; k++) begin
         chk(byte_valid_o, 1);
         chk({byte_o.data, byte_o.index}, {k == 0 ? OP_PROG : a[8*(6-k)+:8], 3'(k)});
         byte_ready_i = 1;
         cyc(1);
         byte_ready_i = 0;
         cyc(2);
      end
      byte_ready_i = 1;
      cyc(8);
      chk(byte_valid_o, 0);
      // auto-increment with busy shown on the output
      cmd(OP_EBSY, 0, 0);
      cmd(OP_WR_ENABLE, 0, 0);
      cmd(OP_AUTO_INC, a, 5);
      chk(status_o[AUTO_INC_POS], 1);
      u_m.start(1'b0);
      for (int i = 0; i < 2; i++) begin
         busy_i = !i;
         cyc(8);
         chk({sdo_oe_o, sdo_o}, {1'b1, 1'(i)});
      end
      u_m.stop();
      auto_inc_end_i = 1;
      cyc(1);
      auto_inc_end_i = 0;
      cyc(4);
      chk(status_o[AUTO_INC_POS], 0);
      rst_b_i = 0;
      cyc(2);
      rst_b_i = 1;
      cyc(4);
      chk(status_o, STATUS_RESET);
      report_and_stop();
   end
endmodule : tb_serial_flash_spi_front_end
